// ===== hw/dab_bridge.sv
// dual branch actuator bus bridge: host serial channels to two actuator branches,
// diagnostic test keys, setting unit switch-over and function leds
// assumes keys, jack detect and serial lines are asynchronous pins; register port on clock
//
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// [R1] two branches, eight slaves each
// [R2] branches run independently of each other
// [R3] one or two host channels serve branches
// [R4] branch line runs at 1200 baud
// [R5] slaves answer only when polled
// [R6] setting unit plugged reroutes branch traffic
// [R7] switch-over raises host notice
// [R8] diagnostic key tests every branch slave
// [R9] failing slave address shown as flashes
// [R10] flash sequence repeated five times, paused
// [R11] led0 lit when channel1 maps branch b; lit only in swap mode, dark when shared with sel on branch b
// [R12] led1 led4 lit while branch off
// [R13] led2 led5 lit while transmitting
// [R14] led3 led6 lit on any activity
// [R15] shared channel alternates between branches
// [R16] port1 feeds branch a, port2 branch b
// [R17] transaction is instruction then answer
// [R18] flash timing fixed by parameters
module dab_bridge
  import dab_pkg::*;
#(
  parameter int unsigned BIT_CYC = BIT_CYCLES,
  parameter int unsigned ON_CYC = FLASH_ON_CYCLES,
  parameter int unsigned OFF_CYC = FLASH_OFF_CYCLES,
  parameter int unsigned PAUSE_CYC = FLASH_PAUSE_CYCLES,
  parameter int unsigned WAIT_CYC = REPLY_WAIT_CYCLES
) (
  input wire logic clock, // system clock
  input wire logic srst, // synchronous reset, high
  input wire logic [3:0] reg_addr, // register byte address
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [7:0] reg_rdata, // read data, cycle after strobe
  input wire logic host1_txd, // host channel 1 data to device
  output logic host1_rxd, // device data to host channel 1
  input wire logic host2_txd, // host channel 2 data to device
  output logic host2_rxd, // device data to host channel 2
  input wire logic [1:0] br_rx, // branch line receive, a=0 b=1
  output logic [1:0] br_tx, // branch line transmit
  input wire logic [1:0] jack_unit, // setting unit plugged per branch
  output logic [1:0] unit_tx, // traffic rerouted to setting unit
  input wire logic [1:0] unit_rx, // setting unit data back
  input wire logic [1:0] diag_key, // diagnostic keys, pressed high
  output logic [1:0] diag_led, // diagnostic leds
  output logic [6:0] func_led, // function leds 0..6
  output logic host_notice, // switch-over notice level
  output logic irq // interrupt level
);
  localparam int CW = 26; // wide enough for the longest flash pause at the full clock rate
  typedef struct packed {
    logic [1:0] s1_key;
    logic [1:0] s2_key;
    logic [1:0] s1_jk;
    logic [1:0] s2_jk;
    logic [1:0] s1_brx;
    logic [1:0] s2_brx;
    logic [1:0] s1_urx;
    logic [1:0] s2_urx;
    logic s1_h1;
    logic s2_h1;
    logic s1_h2;
    logic s2_h2;
    logic [1:0] key_d, jk_d;
    logic [7:0] ctrl;
    logic [3:0] irq_stat, irq_mask;
    logic [7:0] rdata;
    logic sel; // shared channel current branch
    logic [1:0] act;
  } dab_regs_t;
  typedef struct packed {
    dab_diag_t st;
    logic [2:0] addr;
    logic [2:0] fail_addr;
    logic fail;
    logic [3:0] bitn;
    logic [9:0] sh;
    logic [CW-1:0] cnt;
    logic [3:0] flash_n;
    logic [2:0] rep;
    logic rx_seen;
    logic led;
  } dab_diag_s_t;

  dab_regs_t r_ff, nxt_r;
  dab_diag_s_t d_ff [2];
  dab_diag_s_t nxt_d [2];

  // ctrl bit0 shared channel, bit1 swap, bit2 branch a off, bit3 branch b off
  logic shared, swap;
  logic [1:0] br_off;
  logic [1:0] host_line;
  logic [1:0] diag_busy;
  logic [1:0] diag_txd;
  logic [1:0] to_branch;
  logic [1:0] key_rise;
  logic [1:0] jk_rise;
  logic [1:0] jk_fall;
  logic [1:0] done_ev;

  assign shared = r_ff.ctrl[0];
  assign swap = r_ff.ctrl[1];
  assign br_off = r_ff.ctrl[3:2];

  // test frame: start bit, slave index, probe nibble, stop bit
  function automatic logic [9:0] probe_frame(input logic [2:0] slave);
    probe_frame = {1'b1, TEST_PROBE[7:4], 1'b0, slave, 1'b0};
  endfunction


  // host traffic routed onto each branch
  always_comb begin
    if (shared) begin
      host_line[0] = r_ff.sel ? 1'b1 : r_ff.s2_h1; // [R15]
      host_line[1] = r_ff.sel ? r_ff.s2_h1 : 1'b1; // [R3]
    end else if (swap) begin
      host_line[0] = r_ff.s2_h2;
      host_line[1] = r_ff.s2_h1; // [R11]
    end else begin
      host_line[0] = r_ff.s2_h1; // [R16]
      host_line[1] = r_ff.s2_h2; // [R16]
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_br
      assign diag_busy[g] = (d_ff[g].st == DG_SEND) || (d_ff[g].st == DG_WAIT) || (d_ff[g].st == DG_NEXT);
      assign diag_txd[g] = (d_ff[g].st == DG_SEND) ? d_ff[g].sh[0] : 1'b1;
      assign to_branch[g] = br_off[g] ? 1'b1 : (diag_busy[g] ? diag_txd[g] : host_line[g]);
      assign key_rise[g] = r_ff.s2_key[g] & ~r_ff.key_d[g];
      assign jk_rise[g] = r_ff.s2_jk[g] & ~r_ff.jk_d[g];
      assign jk_fall[g] = ~r_ff.s2_jk[g] & r_ff.jk_d[g];
      assign done_ev[g] = (d_ff[g].st == DG_NEXT) && (d_ff[g].addr == 3'h7);
      // each branch has its own sequencer, nothing shared between them
      always_comb begin
        nxt_d[g] = d_ff[g]; // [R2]
        nxt_d[g].cnt = d_ff[g].cnt + CW'(1);
        case (d_ff[g].st)
          DG_IDLE: begin
            nxt_d[g].led = 1'b0;
            if (key_rise[g] && !br_off[g] && !r_ff.s2_jk[g]) begin
              nxt_d[g].st = DG_SEND; // [R8]
              nxt_d[g].addr = 3'h0;
              nxt_d[g].fail = 1'b0;
              nxt_d[g].bitn = 4'h0;
              nxt_d[g].cnt = '0;
              nxt_d[g].sh = probe_frame(3'h0); // [R17]
            end
          end

          DG_SEND: begin
            if (d_ff[g].cnt == CW'(BIT_CYC - 1)) begin // [R4]
              nxt_d[g].cnt = '0;
              nxt_d[g].sh = {1'b1, d_ff[g].sh[9:1]};
              nxt_d[g].bitn = d_ff[g].bitn + 4'h1;
              if (d_ff[g].bitn == 4'h9) begin
                nxt_d[g].st = DG_WAIT;
                nxt_d[g].rx_seen = 1'b0;
              end
            end
          end

          DG_WAIT: begin
            if (!r_ff.s2_brx[g])
              nxt_d[g].rx_seen = 1'b1; // [R5]
            if (d_ff[g].cnt == CW'(WAIT_CYC - 1)) begin
              nxt_d[g].st = DG_NEXT;
              if (!d_ff[g].rx_seen && !d_ff[g].fail) begin
                nxt_d[g].fail = 1'b1;
                nxt_d[g].fail_addr = d_ff[g].addr;
              end
            end
          end

          DG_NEXT: begin
            nxt_d[g].cnt = '0;
            nxt_d[g].bitn = 4'h0;
            if (d_ff[g].addr == 3'(MAX_SLAVES - 1)) begin // [R1]
              nxt_d[g].st = d_ff[g].fail ? DG_FLASH_ON : DG_IDLE;
              nxt_d[g].rep = 3'h0;
              nxt_d[g].flash_n = 4'h0;
            end else begin
              nxt_d[g].addr = d_ff[g].addr + 3'h1;
              nxt_d[g].st = DG_SEND;
              nxt_d[g].sh = probe_frame(d_ff[g].addr + 3'h1);
            end
          end

          DG_FLASH_ON: begin
            nxt_d[g].led = 1'b1;
            if (d_ff[g].cnt == CW'(ON_CYC - 1)) begin // [R18]
              nxt_d[g].cnt = '0;
              nxt_d[g].led = 1'b0;
              nxt_d[g].flash_n = d_ff[g].flash_n + 4'h1;
              nxt_d[g].st = DG_FLASH_OFF;
            end
          end

          DG_FLASH_OFF: begin
            if (d_ff[g].cnt == CW'(OFF_CYC - 1)) begin
              nxt_d[g].cnt = '0;
              // bus address is index plus one
              if (d_ff[g].flash_n == {1'b0, d_ff[g].fail_addr} + 4'h1) // [R9]
                nxt_d[g].st = DG_PAUSE;
              else
                nxt_d[g].st = DG_FLASH_ON;
            end
          end

          DG_PAUSE: begin
            if (d_ff[g].cnt == CW'(PAUSE_CYC - 1)) begin // [R18]
              nxt_d[g].cnt = '0;
              nxt_d[g].flash_n = 4'h0;
              nxt_d[g].rep = d_ff[g].rep + 3'h1;
              nxt_d[g].st = (d_ff[g].rep == 3'(FLASH_REPEATS - 1)) ? DG_IDLE : DG_FLASH_ON; // [R10]
            end
          end

          default: nxt_d[g].st = DG_IDLE;
        endcase
        // led comes on in the first cycle of every flash
        if (nxt_d[g].st == DG_FLASH_ON && d_ff[g].st != DG_FLASH_ON)
          nxt_d[g].led = 1'b1; // [R18]
        if (srst) begin
          nxt_d[g] = '0;
          nxt_d[g].st = DG_IDLE;
        end
      end
    end
  endgenerate

  always_comb begin
    logic [3:0] ev;
    ev = {done_ev, jk_rise | jk_fall};
    nxt_r = r_ff;
    nxt_r.s1_key = diag_key;
    nxt_r.s2_key = r_ff.s1_key;
    nxt_r.s1_jk = jack_unit;
    nxt_r.s2_jk = r_ff.s1_jk;
    nxt_r.s1_brx = br_rx;
    nxt_r.s2_brx = r_ff.s1_brx;
    nxt_r.s1_urx = unit_rx;
    nxt_r.s2_urx = r_ff.s1_urx;
    nxt_r.s1_h1 = host1_txd;
    nxt_r.s2_h1 = r_ff.s1_h1;
    nxt_r.s1_h2 = host2_txd;
    nxt_r.s2_h2 = r_ff.s1_h2;
    nxt_r.key_d = r_ff.s2_key;
    nxt_r.jk_d = r_ff.s2_jk;
    nxt_r.act = ~to_branch | ~r_ff.s2_brx;
    // shared channel toggles between branches with the host's select write
    nxt_r.rdata = 8'h00;

    if (reg_rd) begin
      case (reg_addr)
        ADDR_CTRL: nxt_r.rdata = r_ff.ctrl;
        ADDR_STATUS: nxt_r.rdata = {2'h0, r_ff.s2_jk, diag_busy, d_ff[1].fail, d_ff[0].fail};
        ADDR_IRQ_STAT: nxt_r.rdata = {4'h0, r_ff.irq_stat};
        ADDR_IRQ_MASK: nxt_r.rdata = {4'h0, r_ff.irq_mask};
        default: nxt_r.rdata = 8'h00;
      endcase
    end

    if (reg_wr) begin
      case (reg_addr)
        ADDR_CTRL: begin
          nxt_r.ctrl = reg_wdata;
          if (reg_wdata[4])
            nxt_r.sel = ~r_ff.sel; // [R15]
        end
        ADDR_IRQ_STAT: nxt_r.irq_stat = r_ff.irq_stat & ~reg_wdata[3:0];
        ADDR_IRQ_MASK: nxt_r.irq_mask = reg_wdata[3:0];
        default: ;
      endcase
    end

    nxt_r.irq_stat = nxt_r.irq_stat | ev; // [R7]
    nxt_r.ctrl[7:4] = 4'h0;
    if (srst) begin
      nxt_r = '0;
      nxt_r.ctrl = CTRL_RESET;
      // serial line synchronisers start at the idle level so no false start bit follows reset
      nxt_r.s1_h1 = 1'b1;
      nxt_r.s2_h1 = 1'b1;
      nxt_r.s1_h2 = 1'b1;
      nxt_r.s2_h2 = 1'b1;
      nxt_r.s1_brx = 2'b11;
      nxt_r.s2_brx = 2'b11;
      nxt_r.s1_urx = 2'b11;
      nxt_r.s2_urx = 2'b11;
    end
  end

  always_ff @(posedge clock) begin
    r_ff <= nxt_r;
    d_ff <= nxt_d;
  end

  logic [1:0] from_branch;
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      from_branch[i] = r_ff.s2_jk[i] ? 1'b1 : r_ff.s2_brx[i]; // [R6]
      br_tx[i] = r_ff.s2_jk[i] ? 1'b1 : to_branch[i]; // [R6]
      unit_tx[i] = r_ff.s2_jk[i] ? host_line[i] : 1'b1;
      if (r_ff.s2_jk[i])
        from_branch[i] = r_ff.s2_urx[i];
    end

    if (shared) begin
      host1_rxd = r_ff.sel ? from_branch[1] : from_branch[0];
      host2_rxd = 1'b1;
    end else if (swap) begin
      host1_rxd = from_branch[1];
      host2_rxd = from_branch[0];
    end else begin
      host1_rxd = from_branch[0];
      host2_rxd = from_branch[1];
    end
  end

  assign reg_rdata = r_ff.rdata;
  assign host_notice = |r_ff.s2_jk; // [R7]
  assign irq = |(r_ff.irq_stat & r_ff.irq_mask);
  assign diag_led = {d_ff[1].led, d_ff[0].led}; // [R9]
  assign func_led[0] = swap & ~shared; // [R11]
  assign func_led[1] = br_off[0]; // [R12]
  assign func_led[4] = br_off[1]; // [R12]
  assign func_led[2] = ~to_branch[0]; // [R13]
  assign func_led[5] = ~to_branch[1]; // [R13]
  assign func_led[3] = r_ff.act[0]; // [R14]
  assign func_led[6] = r_ff.act[1]; // [R14]
endmodule
`default_nettype wire

// ===== hw/dab_pkg.sv
// package for the dual branch actuator bus bridge
// assumes a 25 mhz system clock
package dab_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned LINK_BAUD = 1200;
  localparam int unsigned BIT_CYCLES = CLK_HZ / LINK_BAUD;
  localparam int unsigned HALF_BIT_CYCLES = BIT_CYCLES / 2;
  localparam int unsigned MAX_SLAVES = 8;
  localparam int unsigned FLASH_REPEATS = 5;
  localparam int unsigned FLASH_ON_MS = 200;
  localparam int unsigned FLASH_OFF_MS = 300;
  localparam int unsigned FLASH_PAUSE_MS = 1500;
  localparam int unsigned REPLY_WAIT_MS = 100;
  localparam int unsigned FLASH_ON_CYCLES = FLASH_ON_MS * (CLK_HZ / 1000);
  localparam int unsigned FLASH_OFF_CYCLES = FLASH_OFF_MS * (CLK_HZ / 1000);
  localparam int unsigned FLASH_PAUSE_CYCLES = FLASH_PAUSE_MS * (CLK_HZ / 1000);
  localparam int unsigned REPLY_WAIT_CYCLES = REPLY_WAIT_MS * (CLK_HZ / 1000);
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h8;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'hc;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] TEST_PROBE = 8'h55;
  typedef enum {DG_IDLE, DG_SEND, DG_WAIT, DG_NEXT, DG_FLASH_ON, DG_FLASH_OFF, DG_PAUSE} dab_diag_t;
endpackage

// ===== tb/dab_bridge_monitor.sv
// port checker for the bridge, bound to dab_bridge
// assumes the bench sets on and off flash times of 3 cycles
`timescale 1ns/100ps
`default_nettype none
module dab_monitor
  import dab_pkg::*;
(
  input wire logic clock, // clock
  input wire logic srst, // reset
  input wire logic [3:0] reg_addr, // address
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // write
  input wire logic reg_rd, // read
  input wire logic [7:0] reg_rdata, // read data
  input wire logic [1:0] br_rx, // branch rx
  input wire logic [1:0] br_tx, // branch tx
  input wire logic [1:0] jack_unit, // unit plugged
  input wire logic [1:0] diag_led, // diag leds
  input wire logic [6:0] func_led, // function leds
  input wire logic host_notice, // notice
  input wire logic irq // interrupt
);
  logic [7:0] wd_ff;
  always_ff @(posedge clock) wd_ff <= reg_wdata;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  sequence s_flash_a;
    diag_led[0] [*3] ##1 !diag_led[0] [*3];
  endsequence
  sequence s_flash_b;
    diag_led[1] [*3] ##1 !diag_led[1] [*3];
  endsequence
  a_ctrl_leds: assert property (reg_wr && reg_addr == ADDR_CTRL && !reg_wdata[0] |=>
    func_led[0] == wd_ff[1] && func_led[1] == wd_ff[2] && func_led[4] == wd_ff[3]) else $error("ctrl leds wrong");
  a_notice_rise: assert property ($rose(jack_unit[0]) |-> ##[1:4] host_notice) else $error("no notice");
  a_notice_drop: assert property ((jack_unit == 2'b00) [*4] |-> !host_notice) else $error("notice stuck");
  a_unit_route: assert property (jack_unit[0] [*4] |-> br_tx[0]) else $error("branch not idle");
  a_tx_led: assert property (!br_tx[0] |-> ##[0:1] (func_led[2] && func_led[3])) else $error("tx led dark");
  a_act_b: assert property (!br_rx[1] && !jack_unit[1] |-> ##[0:3] func_led[6]) else $error("act led dark");
  a_flash_a: assert property ($rose(diag_led[0]) |-> s_flash_a) else $error("flash a timing");
  a_flash_b: assert property ($rose(diag_led[1]) |-> s_flash_b) else $error("flash b timing");
endmodule
bind dab_bridge dab_monitor i_mon (.clock, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .br_rx, .br_tx, .jack_unit, .diag_led, .func_led, .host_notice, .irq);
`default_nettype wire

// ===== tb/dab_slaves.sv
// slave actuators on both branches: answer each polled frame but the silent address with a start bit
// assumes 10 bit frames of BIT_CYC cycles per bit, lines idle high
`timescale 1ns/100ps
`default_nettype none
module dab_slaves #(
  parameter int BIT_CYC = 4
) (
  input wire logic clock, // clock
  input wire logic clr, // restart frame count
  input wire logic [1:0] br_tx, // frames from bridge
  input wire logic [7:0] dead, // silent address per branch, 0 none
  output logic [1:0] br_rx // answers
);
  for (genvar b = 0; b < 2; b++) begin : g_br
    int busy = 0;
    int ans = 0;
    int cnt = 0;
    always @(posedge clock) begin
      if (clr) begin
        cnt <= 0;
      end else if (busy > 0) begin
        busy <= busy - 1;
        if (busy == 1) begin
          cnt <= cnt + 1;
          if (cnt + 1 != dead[b*4 +: 4]) ans <= BIT_CYC;
        end
      end else if (!br_tx[b]) begin
        busy <= 10 * BIT_CYC - 1;
      end
      if (ans > 0) ans <= ans - 1;
    end
    assign br_rx[b] = (ans == 0);
  end
endmodule
`default_nettype wire

// ===== tb/test_dab_bridge.sv
// self-checking bench for the bridge with shortened timing parameters
// assumes dab_slaves answers every frame except the silent address
`timescale 1ns/100ps
`default_nettype none
module test_dab_bridge;
  import dab_pkg::*;
  logic clock = 0, srst = 1, reg_wr = 0, reg_rd = 0, host1_txd = 1, host2_txd = 1, rd_ff = 0, clr = 1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, dead = 8'h03, h, c;
  logic [1:0] br_rx, br_tx, unit_tx, diag_led, e, led_d, jack_unit = 0, unit_rx = 2'b11, diag_key = 0;
  logic [6:0] func_led;
  logic host1_rxd, host2_rxd, host_notice, irq;
  logic [7:0] exp_q[$];
  int fail_count = 0, num_checks = 0, seed = 3004, rises_a, rises_b;
  always #20 clock = ~clock;
  dab_bridge #(.BIT_CYC(4), .ON_CYC(3), .OFF_CYC(3), .PAUSE_CYC(5), .WAIT_CYC(40)) i_dut (.clock, .srst,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .host1_txd, .host1_rxd, .host2_txd, .host2_rxd,
    .br_rx, .br_tx, .jack_unit, .unit_tx, .unit_rx, .diag_key, .diag_led, .func_led, .host_notice, .irq);
  dab_slaves #(.BIT_CYC(4)) i_slaves (.clock, .clr, .br_tx, .dead, .br_rx);
  task automatic conclude();
    $display("checks %0d failures %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    exp_q.push_back(exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
  endtask
  // read results are compared by this watcher in the cycle after the strobe
  always @(posedge clock) rd_ff <= reg_rd;
  always @(negedge clock) if (rd_ff) chk(reg_rdata, exp_q.pop_front());
  initial begin
    #(20000 * 40);
    fail_count++;
    conclude();
  end
  initial begin
    cyc(8);
    srst <= 1'b0;
    clr <= 1'b0;
    @(posedge clock);
    rd(ADDR_CTRL, CTRL_RESET);
    rd(ADDR_STATUS, 8'h00);
    rd(ADDR_IRQ_MASK, 8'h00);
    wr(4'h2, 8'hff);
    rd(4'h2, 8'h00);
    for (int i = 0; i < 24; i++) begin
      c = (i % 3 == 0) ? 8'h00 : (i % 3 == 1) ? 8'h02 : 8'h01;
      wr(ADDR_CTRL, c);
      h = $random(seed);
      host1_txd <= h[0];
      host2_txd <= h[1];
      cyc(4);
      e = c[1] ? {h[0], h[1]} : c[0] ? {1'b1, h[0]} : h[1:0];
      chk({br_tx, func_led[0], func_led[2], func_led[5]}, {e, c[1], ~e[0], ~e[1]});
    end
    wr(ADDR_CTRL, 8'h11);
    host1_txd <= 1'b0;
    host2_txd <= 1'b1;
    cyc(4);
    chk(br_tx, 2'b01);
    wr(ADDR_CTRL, 8'h0c);
    cyc(2);
    chk({br_tx, func_led[1], func_led[4]}, 4'hf);
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_IRQ_MASK, 8'h0f);
    jack_unit <= 2'b01;
    unit_rx <= 2'b10;
    cyc(4);
    chk({host_notice, irq, unit_tx[0], br_tx[0], host1_rxd}, 5'b11010);
    rd(ADDR_IRQ_STAT, 8'h01);
    rd(ADDR_STATUS, 8'h10);
    wr(ADDR_IRQ_STAT, 8'h01);
    rd(ADDR_IRQ_STAT, 8'h00);
    jack_unit <= 2'b00;
    host1_txd <= 1'b1;
    unit_rx <= 2'b11;
    cyc(4);
    rd(ADDR_IRQ_STAT, 8'h01);
    wr(ADDR_IRQ_MASK, 8'h00);
    chk(irq, 1'b0);
    wr(ADDR_IRQ_STAT, 8'h0f);
    wr(ADDR_IRQ_MASK, 8'h0c);
    clr <= 1'b1;
    diag_key <= 2'b11;
    cyc(2);
    clr <= 1'b0;
    diag_key <= 2'b00;
    rises_a = 0;
    rises_b = 0;
    led_d = 2'b00;
    repeat (3000) begin
      @(negedge clock);
      rises_a += int'(diag_led[0] && !led_d[0]);
      rises_b += int'(diag_led[1] && !led_d[1]);
      led_d = diag_led;
    end
    chk(8'(rises_a), 8'd15);
    chk(8'(rises_b), 8'd0);
    chk(irq, 1'b1);
    rd(ADDR_IRQ_STAT, 8'h0c);
    rd(ADDR_STATUS, 8'h01);
    conclude();
  end
endmodule
`default_nettype wire
